/* hw/ladder_dac_control.sv */
// Overview of operation
// - Control bit 7 turns the ladder on; off means no level produced.
// - Control bit 5 routes the level to pin A.
// - Control bit 4 routes the level to pin B.
// - Bits 3-2 pick top: 00 supply, 01 ext ref, 10 fixed buffer, 11 reserved.
// - Control bit 0 picks bottom: 1 external negative ref, 0 ground.
// - Low five bits of the level register form the 32-step code.
// - Output is bottom plus difference times code over 32.
// - Routed pin loses its driver, pull-up and input detector.
// - A routed pin always reads back zero.
// - Reset disables ladder, removes pin routing and clears the code.
// - Waking from sleep leaves control contents unchanged.
// - Unimplemented control bits 6,1 and level bits 7-5 read zero.
`default_nettype none
module ladder_dac_control
   import ladder_dac_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic ladderOn,
   output logic [1:0] topSourceSelect,
   output logic bottomSourceSelect,
   output logic [4:0] levelCode,
   input wire logic pinAOut,
   input wire logic pinAOeN,
   input wire logic pinAPullUp,
   input wire logic pinAIn,
   input wire logic pinBOut,
   input wire logic pinBOeN,
   input wire logic pinBPullUp,
   input wire logic pinBIn,
   output logic refOutPinAOeN,
   output logic refOutPinAOut,
   output logic refOutPinAPullUp,
   output logic refOutPinAInEn,
   output logic refOutPinBOeN,
   output logic refOutPinBOut,
   output logic refOutPinBPullUp,
   output logic refOutPinBInEn,
   output logic refOutPinAConnect,
   output logic refOutPinBConnect
);
   logic [7:0] control_q;
   logic [7:0] level_q;
   bus_state_t busState_q;
   logic [1:0] routeVec;
   logic [1:0] outVec;
   logic [1:0] oeNVec;
   logic [1:0] pullUpVec;
   logic [1:0] inVec;
   wire logic [1:0] padOeNVec;
   wire logic [1:0] padOutVec;
   wire logic [1:0] padPullUpVec;
   wire logic [1:0] padInEnVec;
   wire logic [1:0] readVec;
   logic accept;
   logic [7:0] readByte;

   // ***************************************************************
   // Avalon slave: one wait cycle, answer on second edge
   // ***************************************************************
   assign accept = (avs_read | avs_write) && busState_q == BUS_IDLE;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busState_q <= BUS_IDLE;
      end else begin
         case (busState_q)
            BUS_IDLE: begin
               if (avs_read | avs_write) begin
                  busState_q <= BUS_DONE;
               end
            end
            BUS_DONE: busState_q <= BUS_IDLE;
            default: busState_q <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~accept;
      end
   end

   // ***************************************************************
   // Registers; no sleep input exists, so wake cannot disturb them
   // ***************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         control_q <= CONTROL_RESET;
         level_q <= LEVEL_RESET;
      end else if (avs_write && accept && avs_byteenable[0]) begin
         if (avs_address == ADDR_CONTROL) begin
            control_q <= avs_writedata[7:0] & CONTROL_MASK;
         end
         if (avs_address == ADDR_LEVEL) begin
            level_q <= avs_writedata[7:0] & LEVEL_MASK;
         end
      end
   end

   always_comb begin
      case (avs_address)
         ADDR_CONTROL: readByte = control_q;
         ADDR_LEVEL: readByte = level_q;
         ADDR_PIN_IN: readByte = {6'h00, readVec};
         default: readByte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (accept && avs_read) begin
         avs_readdata <= {24'h00_0000, readByte};
      end
   end

   // ***************************************************************
   // Analog controls, one edge after the register write
   // ***************************************************************
   // Ladder sees zero code when off, so nothing is produced
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ladderOn <= 1'b0;
         topSourceSelect <= TOP_ANALOG_SUPPLY;
         bottomSourceSelect <= 1'b0;
         levelCode <= 5'h00;
         refOutPinAConnect <= 1'b0;
         refOutPinBConnect <= 1'b0;
      end else begin
         ladderOn <= control_q[BIT_LADDER_ON];
         topSourceSelect <= control_q[TOP_SEL_HI:TOP_SEL_LO];
         bottomSourceSelect <= control_q[BIT_BOTTOM_SEL];
         levelCode <= control_q[BIT_LADDER_ON] ?
            level_q[LEVEL_BITS-1:0] : 5'h00;
         refOutPinAConnect <= control_q[BIT_PIN_A_ROUTE];
         refOutPinBConnect <= control_q[BIT_PIN_B_ROUTE];
      end
   end

   // ***************************************************************
   // Pin override, one copy per pin: bit 0 pin A, bit 1 pin B
   // ***************************************************************
   assign routeVec = {control_q[BIT_PIN_B_ROUTE],
      control_q[BIT_PIN_A_ROUTE]};
   assign outVec = {pinBOut, pinAOut};
   assign oeNVec = {pinBOeN, pinAOeN};
   assign pullUpVec = {pinBPullUp, pinAPullUp};
   assign inVec = {pinBIn, pinAIn};

   // Routing from control_q so pads switch with the analog outputs
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_pin
         ladder_pin_route pinRoute (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .routeOn(routeVec[ch]),
            .pinOut(outVec[ch]),
            .pinOeN(oeNVec[ch]),
            .pinPullUp(pullUpVec[ch]),
            .pinIn(inVec[ch]),
            .padOeN(padOeNVec[ch]),
            .padOut(padOutVec[ch]),
            .padPullUp(padPullUpVec[ch]),
            .padInEn(padInEnVec[ch]),
            .pinRead(readVec[ch])
         );
      end
   endgenerate

   assign refOutPinAOeN = padOeNVec[0];
   assign refOutPinAOut = padOutVec[0];
   assign refOutPinAPullUp = padPullUpVec[0];
   assign refOutPinAInEn = padInEnVec[0];
   assign refOutPinBOeN = padOeNVec[1];
   assign refOutPinBOut = padOutVec[1];
   assign refOutPinBPullUp = padPullUpVec[1];
   assign refOutPinBInEn = padInEnVec[1];

   // ***************************************************************
   // Checks
   // ***************************************************************
   sequence s_ctrlWrite;
      avs_write && accept && avs_byteenable[0] &&
         avs_address == ADDR_CONTROL;
   endsequence

   sequence s_levelWrite;
      avs_write && accept && avs_byteenable[0] &&
         avs_address == ADDR_LEVEL;
   endsequence

   sequence s_readTaken;
      avs_read && accept;
   endsequence

   sequence s_laneRefused;
      avs_write && accept && !avs_byteenable[0];
   endsequence

   // Outputs lag the accepting edge by one, hence two edges
   a_ladder_on_follow: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_ctrlWrite |-> ##2
      ladderOn == $past(avs_writedata[7], 2))
      else $error("ladder enable did not follow write");

   a_pin_a_route: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_ctrlWrite |-> ##2
      refOutPinAConnect == $past(avs_writedata[5], 2))
      else $error("pin A routing wrong");

   a_pin_b_route: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_ctrlWrite |-> ##2
      refOutPinBConnect == $past(avs_writedata[4], 2))
      else $error("pin B routing wrong");

   a_top_select: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_ctrlWrite |-> ##2
      topSourceSelect == $past(avs_writedata[3:2], 2))
      else $error("top source wrong");

   a_bottom_select: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_ctrlWrite |-> ##2
      bottomSourceSelect == $past(avs_writedata[0], 2))
      else $error("bottom source wrong");

   a_level_code_off: assert property (@(posedge core_clk)
      disable iff (!rst_n) !ladderOn |-> levelCode == 5'h00)
      else $error("code present while off");

   a_pin_read_zero: assert property (@(posedge core_clk)
      disable iff (!rst_n) $past(control_q[BIT_PIN_A_ROUTE]) |->
      !readVec[0] && refOutPinAOeN && !refOutPinAPullUp)
      else $error("routed pin not overridden");

   a_unused_zero: assert property (@(posedge core_clk)
      disable iff (!rst_n) (control_q & ~CONTROL_MASK) == 8'h00 &&
      (level_q & ~LEVEL_MASK) == 8'h00)
      else $error("unimplemented bit set");

   a_wait_bounded: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(avs_read | avs_write) |->
      ##[1:2] !avs_waitrequest)
      else $error("bus answer late");

   a_level_follow: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_levelWrite |-> ##2
      levelCode == (ladderOn ? $past(avs_writedata[4:0], 2) : 5'h00))
      else $error("level code did not follow write");

   a_level_clean: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_levelWrite |=>
      level_q == {3'h0, $past(avs_writedata[4:0])})
      else $error("level register holds wrong value");

   a_read_answer: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_readTaken |=> !avs_waitrequest &&
      avs_readdata[31:8] == 24'h00_0000)
      else $error("read answer malformed");

   a_read_hold: assert property (@(posedge core_clk)
      disable iff (!rst_n) !(avs_read && accept) |=>
      $stable(avs_readdata))
      else $error("read data changed without a read");

   a_lane_refused: assert property (@(posedge core_clk)
      disable iff (!rst_n) s_laneRefused |=> $stable(control_q) &&
      $stable(level_q))
      else $error("write without low lane landed");

   a_wait_single: assert property (@(posedge core_clk)
      disable iff (!rst_n) !avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");

   a_pin_a_detector: assert property (@(posedge core_clk)
      disable iff (!rst_n) $past(control_q[BIT_PIN_A_ROUTE]) |->
      !refOutPinAOut && !refOutPinAInEn)
      else $error("pin A driver or detector left on");

   a_pin_b_override: assert property (@(posedge core_clk)
      disable iff (!rst_n) $past(control_q[BIT_PIN_B_ROUTE]) |->
      !readVec[1] && refOutPinBOeN && !refOutPinBPullUp &&
      !refOutPinBOut && !refOutPinBInEn)
      else $error("pin B not overridden");

   a_reset_clear: assert property (@(posedge core_clk)
      disable iff (!rst_n) $rose(rst_n) |-> !ladderOn &&
      !refOutPinAConnect && !refOutPinBConnect && levelCode == 5'h00 &&
      control_q == CONTROL_RESET && level_q == LEVEL_RESET)
      else $error("reset left state behind");
endmodule
`default_nettype wire

/* hw/ladder_dac_pkg.sv */
`default_nettype none
package ladder_dac_pkg;
   // ***************************************************************
   // Register map (byte addresses, one word each)
   // ***************************************************************
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_LEVEL = 4'h4;
   localparam logic [3:0] ADDR_PIN_IN = 4'h8;

   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int BIT_LADDER_ON = 7;
   localparam int BIT_PIN_A_ROUTE = 5;
   localparam int BIT_PIN_B_ROUTE = 4;
   localparam int TOP_SEL_HI = 3;
   localparam int TOP_SEL_LO = 2;
   localparam int BIT_BOTTOM_SEL = 0;
   localparam logic [7:0] CONTROL_MASK = 8'hbd;
   localparam logic [7:0] LEVEL_MASK = 8'h1f;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam int LEVEL_BITS = 5;

   // ***************************************************************
   // Source selections
   // ***************************************************************
   typedef enum logic [1:0] {
      TOP_ANALOG_SUPPLY = 2'h0,
      TOP_EXT_REF = 2'h1,
      TOP_FIXED_REF_BUFFER = 2'h2,
      TOP_RESERVED = 2'h3
   } top_source_t;

   // Bus answer states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h1,
      BUS_DONE = 2'h2
   } bus_state_t;
endpackage
`default_nettype wire

/* hw/ladder_pin_route.sv */
`default_nettype none
module ladder_pin_route
   import ladder_dac_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic routeOn,
   input wire logic pinOut,
   input wire logic pinOeN,
   input wire logic pinPullUp,
   input wire logic pinIn,
   output logic padOeN,
   output logic padOut,
   output logic padPullUp,
   output logic padInEn,
   output logic pinRead
);
   // Routed pin loses driver, pull-up and input detector; reads zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         padOeN <= 1'b1;
         padOut <= 1'b0;
         padPullUp <= 1'b0;
         padInEn <= 1'b0;
         pinRead <= 1'b0;
      end else begin
         padOeN <= routeOn ? 1'b1 : pinOeN;
         padOut <= routeOn ? 1'b0 : pinOut;
         padPullUp <= routeOn ? 1'b0 : pinPullUp;
         padInEn <= ~routeOn;
         pinRead <= routeOn ? 1'b0 : pinIn;
      end
   end
endmodule
`default_nettype wire

/* tb/ladder_pin_model.sv */
`default_nettype none
module ladder_pin_model (
   input wire logic padOeN,
   input wire logic padOut,
   input wire logic padPullUp,
   input wire logic padInEn,
   input wire logic extLevel,
   output logic pinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wireLevel;
   // Released line goes to the pull-up, else to the outside level
   assign wireLevel = !padOeN ? padOut : (padPullUp | extLevel);
   // Detector switched off yields no digital level
   assign pinIn = padInEn & wireLevel;
endmodule
`default_nettype wire

/* tb/tb_ladder_dac_control.sv */
`default_nettype none
module tb_ladder_dac_control;
   import ladder_dac_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rdata;
   logic ladderOn, bottomSourceSelect, extA, extB, inA, inB;
   logic [1:0] topSourceSelect;
   logic [4:0] levelCode;
   logic [2:0] pinA, pinB;
   logic aOe, aOut, aPu, aIn, bOe, bOut, bPu, bIn, aCon, bCon;
   logic [7:0] ctl, lvl;
   int n_errors = 0, comparisons = 0, cycles = 0;
   ladder_dac_control dut (.core_clk(core_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ladderOn(ladderOn),
      .topSourceSelect(topSourceSelect),
      .bottomSourceSelect(bottomSourceSelect), .levelCode(levelCode),
      .pinAOut(pinA[2]), .pinAOeN(pinA[1]), .pinAPullUp(pinA[0]),
      .pinAIn(inA), .pinBOut(pinB[2]), .pinBOeN(pinB[1]),
      .pinBPullUp(pinB[0]), .pinBIn(inB), .refOutPinAOeN(aOe),
      .refOutPinAOut(aOut), .refOutPinAPullUp(aPu), .refOutPinAInEn(aIn),
      .refOutPinBOeN(bOe), .refOutPinBOut(bOut), .refOutPinBPullUp(bPu),
      .refOutPinBInEn(bIn), .refOutPinAConnect(aCon),
      .refOutPinBConnect(bCon));
   ladder_pin_model pinModelA (.padOeN(aOe), .padOut(aOut),
      .padPullUp(aPu), .padInEn(aIn), .extLevel(extA), .pinIn(inA));
   ladder_pin_model pinModelB (.padOeN(bOe), .padOut(bOut),
      .padPullUp(bPu), .padInEn(bIn), .extLevel(extB), .pinIn(inB));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   always #20 core_clk = ~core_clk;
   task automatic stop_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   function automatic logic [3:0] padExp(logic r, logic [2:0] p);
      return r ? 4'h8 : {p[1], p[2], p[0], 1'b1};
   endfunction
   function automatic logic pinExp(logic r, logic [2:0] p, logic e);
      return r ? 1'b0 : (!p[1] ? p[2] : (p[0] | e));
   endfunction
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      core_clk = 0;
      rst_n = 0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      {pinA, pinB, extA, extB} = '0;
      void'($urandom(32'h8e109c5c));
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 44; i++) begin
         if (i == 0 || i == 43) begin
            // Reset values, after power-up and after a mid-run reset
            #1;
            check({ladderOn, aCon, bCon, levelCode}, 0);
            xfer(0, ADDR_CONTROL, 0);
            check(rdata, CONTROL_RESET);
            xfer(0, ADDR_LEVEL, 0);
            check(rdata, LEVEL_RESET);
         end
         if (i == 43) break;
         ctl = $urandom();
         lvl = $urandom();
         if (i < 4) ctl = {2'h2, ctl[5:4], i[1:0], ctl[1:0]};
         @(posedge core_clk);
         pinA <= $urandom();
         pinB <= $urandom();
         {extA, extB} <= $urandom();
         xfer(1, ADDR_CONTROL, ctl);
         xfer(1, ADDR_LEVEL, lvl);
         #1;
         check(ladderOn, ctl[7]);
         check(aCon, ctl[5]);
         check(bCon, ctl[4]);
         check(topSourceSelect, ctl[3:2]);
         check(bottomSourceSelect, ctl[0]);
         check(levelCode, ctl[7] ? lvl[4:0] : 5'h0);
         check({aOe, aOut, aPu, aIn}, padExp(ctl[5], pinA));
         check({bOe, bOut, bPu, bIn}, padExp(ctl[4], pinB));
         xfer(0, ADDR_CONTROL, 0);
         check(rdata, ctl & CONTROL_MASK);
         xfer(0, ADDR_LEVEL, 0);
         check(rdata, lvl & LEVEL_MASK);
         xfer(0, ADDR_PIN_IN, 0);
         check(rdata, {pinExp(ctl[4], pinB, extB),
                       pinExp(ctl[5], pinA, extA)});
         if (i == 42) begin
            // Refused writes leave the registers alone
            xfer(1, ADDR_CONTROL, 8'hff);
            avs_byteenable <= 4'he;
            xfer(1, ADDR_CONTROL, 8'h00);
            avs_byteenable <= 4'hf;
            xfer(1, ADDR_PIN_IN, 8'h00);
            xfer(1, 4'hc, 8'h00);
            repeat (30) @(posedge core_clk);
            xfer(0, ADDR_CONTROL, 0);
            check(rdata, CONTROL_MASK);
            xfer(0, 4'hc, 0);
            check(rdata, 0);
            @(posedge core_clk);
            rst_n <= 1'b0;
            repeat (2) @(posedge core_clk);
            rst_n <= 1'b1;
         end
      end
      // Ladder switched off before going idle
      xfer(1, ADDR_CONTROL, 8'h00);
      #1;
      check({ladderOn, levelCode}, 0);
      stop_test();
   end
endmodule
`default_nettype wire
